// ==== bench/adc_device_model.sv ====
// Behavioural model of the converter's write-only serial port.
`timescale 1ns/100ps
module adc_device_model (
  input wire hw_reset,             // Device reset, active high.
  input wire serial_port_select_b, // Serial enable, active low.
  input wire sclk,                 // Serial clock from the host.
  input wire sdata                 // Serial data from the host.
);
  logic [15:0] shift;       // Frame bits, first bit on top.
  int          nbit = -1;   // Bits in this frame, negative when idle.
  int          nbad, n_pulse; // Bad frames and reset pulses.
  realtime     rel_t, t0;   // Last reset release and frame start.
  logic [15:0] frames[$];   // Finished writes, address then data.
  realtime     fs[$], fe[$]; // Frame start and end times.
  // Each pulse reloads the trims; only its count and end matter here.
  always @(posedge hw_reset) n_pulse++;
  always @(negedge hw_reset) rel_t = $realtime;
  always @(negedge serial_port_select_b) begin
    nbit = 0;
    t0 = $realtime;
  end
  // Bits are taken on the rising serial clock, address byte first.
  always @(posedge sclk) if (nbit >= 0) begin
    shift = {shift[14:0], sdata};
    nbit++;
  end
  // A frame of another length is no write, so it is counted and timed but not kept.
  always @(posedge serial_port_select_b) if (nbit >= 0) begin
    if (nbit == 16) frames.push_back(shift);
    else nbad++;
    fs.push_back(t0);
    fe.push_back($realtime);
    nbit = -1;
  end
endmodule // adc_device_model

// ==== bench/adc_startup_config_sequencer_tb_top.sv ====
// Self-checking bench for the converter start-up sequencer.
`timescale 1ns/100ps
`include "startup_seq_consts.vh"
module adc_startup_config_sequencer_tb_top;
  localparam int PU = 50, RL = 40, CL = 100; // Shortened waits.
  logic        clk_sys = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, clocks_ready = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00, got;
  wire  [7:0]  rdata;
  wire         hw_reset, serial_port_select_b, sclk, sdata, done;
  int          n_mismatch, n_tests, n, div;
  // Expected writes in order, address in the upper byte.
  logic [15:0] exp_q[$] = '{16'h0081, 16'h1100, 16'h1201, 16'h1300, 16'hA503, 16'hA620, 16'hAB03,
    16'hAC03, 16'hAD08, 16'hAE08, 16'h6402, 16'h1100, 16'h1260, 16'h1300, 16'h260F, 16'h2080,
    16'h11FF, 16'h1200, 16'h1300, 16'hD508, 16'hD500, 16'h2A00, 16'hCF50, 16'h1100, 16'h121E,
    16'h1300, 16'h2D02, 16'h1100, 16'h1201, 16'h1300, 16'h8C02, 16'hB701, 16'hB700, 16'h1100,
    16'h1200, 16'h1301, 16'h6A02};
  adc_startup_config_sequencer #(.POWERUP_CYCLES(PU), .RELEASE_CYCLES(RL), .CAL_CYCLES(CL)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .clocks_ready(clocks_ready), .hw_reset(hw_reset), .serial_port_select_b(serial_port_select_b),
    .sclk(sclk), .sdata(sdata), .done(done));
  adc_device_model m (.hw_reset(hw_reset), .serial_port_select_b(serial_port_select_b),
    .sclk(sclk), .sdata(sdata));
  always #2.5 clk_sys = ~clk_sys;
  // Sampling 1 ns after the edge keeps reads clear of the edge's own updates.
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask
  task automatic ok(input logic c, input string s);
    chk({15'h0000, c}, 16'h0001, s);
  endtask
  // A spare cycle after each strobe keeps one assignment per time step.
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc();
    wr <= 1'b0;
    cyc();
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    cyc();
    d = rdata;
    rd <= 1'b0;
    cyc();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs well under this.
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence: registers first, then one full start-up run.
  initial begin
    void'($urandom(57));
    div = $urandom_range(6, 1);
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc();
    rd_reg(`REG_DIVIDER, got);
    chk(got, `DIVIDER_RESET, "divider reset value");
    rd_reg(`REG_STATUS, got);
    chk(got, 8'h00, "status reset value");
    wr_reg(`REG_DIVIDER, 8'h00);
    rd_reg(`REG_DIVIDER, got);
    chk(got, `DIVIDER_RESET, "zero divider taken");
    wr_reg(`REG_DIVIDER, div[7:0]);
    rd_reg(`REG_DIVIDER, got);
    chk(got, div[7:0], "divider value");
    wr_reg(`REG_CONTROL, 8'h01);
    repeat (PU + 20) cyc();
    ok(hw_reset === 1'b0 && serial_port_select_b === 1'b1, "moved before clocks");
    clocks_ready <= 1'b1;
    for (n = 0; n < 1000 && hw_reset !== 1'b1; n++) cyc();
    ok(n >= PU && n < 1000, "power-up wait");
    for (n = 0; n < 100 && hw_reset === 1'b1; n++) cyc();
    ok(n >= `RESET_CYCLES, "reset pulse width");
    for (n = 0; n < 20000 && m.frames.size() < 20; n++) cyc();
    // The gap after the enabling write may last divider+1 cycles before the wait begins.
    repeat (10) cyc();
    rd_reg(`REG_STATUS, got);
    ok(got[`STAT_CAL_BIT] === 1'b1 && got[`STAT_BUSY_BIT] === 1'b1, "calibration status");
    wr_reg(`REG_CONTROL, 8'h01);
    for (n = 0; n < 40000 && done !== 1'b1; n++) cyc();
    ok(done === 1'b1, "no finish");
    rd_reg(`REG_STATUS, got);
    chk(got, 8'h02, "final status");
    rd_reg(`REG_STEP, got);
    chk(got, 8'h25, "final step count");
    repeat (50) cyc();
    ok(m.frames.size() == 37 && m.nbad == 0, "write count");
    foreach (exp_q[i]) chk(m.frames[i], exp_q[i], "write");
    ok(m.fs[20] - m.fe[19] >= CL * 5.0, "calibration time");
    ok(m.fs[0] - m.rel_t >= RL * 5.0, "release wait");
    ok(m.n_pulse == 1, "one reset pulse");
    // A second reset after the finished run must clear the finish flag and the reset, select and clock pins.
    rst_b <= 1'b0;
    cyc();
    ok(done === 1'b0 && hw_reset === 1'b0 && serial_port_select_b === 1'b1 && sclk === 1'b0, "reset values");
    rst_b <= 1'b1;
    cyc();
    rd_reg(`REG_STATUS, got);
    chk(got, 8'h00, "status after reset");
    report_and_stop();
  end
endmodule // adc_startup_config_sequencer_tb_top

// ==== bench/startup_seq_assertions.sv ====
// Checker for the sequencer's device reset and serial pins.
`timescale 1ns/100ps
module startup_seq_checker #(parameter RELEASE_CYCLES = 40) (
  input wire clk_sys,              // System clock.
  input wire rst_b,                // Reset, active low.
  input wire clocks_ready,         // Clocks running.
  input wire hw_reset,             // Device reset.
  input wire serial_port_select_b, // Serial enable, active low.
  input wire sclk,                 // Serial clock.
  input wire sdata,                // Serial data.
  input wire done                  // Sequence finished.
);
  int         rel_cnt; // Cycles since device reset fell.
  logic [4:0] bits;    // Serial clock rises in this frame.
  logic       sclk_q;  // Serial clock one cycle ago.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // The count saturates so a long run cannot wrap and fake a short wait.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rel_cnt <= 0;
      bits <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      rel_cnt <= hw_reset ? 0 : rel_cnt + (rel_cnt < 100000);
      bits <= serial_port_select_b ? 5'h00 : bits + {4'h0, sclk & ~sclk_q};
      sclk_q <= sclk;
    end
  end
  a_clocks_first: assert property ($rose(hw_reset) |-> clocks_ready)
    else $error("Reset pulse before clocks ran.");
  a_pulse_width: assert property ($rose(hw_reset) |-> hw_reset [*2])
    else $error("Reset pulse too short.");
  a_release_gap: assert property ($fell(serial_port_select_b) |-> rel_cnt >= RELEASE_CYCLES)
    else $error("Frame too soon after reset.");
  a_quiet_reset: assert property (hw_reset |-> serial_port_select_b && !sclk)
    else $error("Serial activity during reset.");
  a_frame_bits: assert property ($rose(serial_port_select_b) |-> bits == 5'h10)
    else $error("Frame is not sixteen bits.");
  a_sclk_idle: assert property (serial_port_select_b |-> !sclk)
    else $error("Serial clock outside a frame.");
  a_data_held: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("Data moved while clock high.");
  a_done_sticky: assert property (done |=> done)
    else $error("Finish flag dropped.");
  a_done_last: assert property (done |-> serial_port_select_b && !hw_reset)
    else $error("Finish flag during activity.");
endmodule // startup_seq_checker

bind adc_startup_config_sequencer startup_seq_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_checker (
  .clk_sys(clk_sys), .rst_b(rst_b), .clocks_ready(clocks_ready), .hw_reset(hw_reset),
  .serial_port_select_b(serial_port_select_b), .sclk(sclk), .sdata(sdata), .done(done));

// ==== src/adc_startup_config_sequencer.v ====
// Host-side sequencer that resets and configures the quad converter over its serial port.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "startup_seq_consts.vh"

module adc_startup_config_sequencer #(
  parameter POWERUP_CYCLES = `POWERUP_CYCLES,       // Cycles waited after power-up.
  parameter RELEASE_CYCLES = `RELEASE_CYCLES,       // Cycles waited after reset release.
  parameter CAL_CYCLES     = `CAL_CYCLES            // Cycles of calibration time.
) (
  input  wire        clk_sys,                       // System clock, 200 MHz.
  input  wire        rst_b,                         // Asynchronous reset, active low.
  input  wire [1:0]  addr,                          // Host register address.
  input  wire [7:0]  wdata,                         // Host write data.
  input  wire        wr,                            // Host write strobe.
  input  wire        rd,                            // Host read strobe.
  output reg  [7:0]  rdata,                         // Host read data, cycle after strobe.
  input  wire        clocks_ready,                  // Sampling clock and reference running.
  output reg         hw_reset,                      // Device hardware reset, active high.
  output reg         serial_port_select_b,          // Serial enable, active low.
  output reg         sclk,                          // Serial clock made by this end.
  output reg         sdata,                         // Serial data to the device.
  output reg         done                           // Sequence finished.
);

  localparam S_IDLE    = 3'd0;
  localparam S_POWERUP = 3'd1;
  localparam S_PULSE   = 3'd2;
  localparam S_RELEASE = 3'd3;
  localparam S_SHIFT   = 3'd4;
  localparam S_GAP     = 3'd5;
  localparam S_CALWAIT = 3'd6;
  localparam S_DONE    = 3'd7;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] timer;
  reg  [5:0]  step;
  reg  [4:0]  bit_cnt;
  reg  [15:0] shift;
  reg  [7:0]  half_cnt;
  reg  [7:0]  divider;
  reg         ready_meta;
  reg         ready_sync;
  reg         start_req;

  // Sequence table: address in the high byte, data in the low byte.
  function [15:0] seq_word;
    input [5:0] idx;
    begin
      case (idx)
        6'd0:    seq_word = 16'h0081;
        6'd1:    seq_word = 16'h1100;
        6'd2:    seq_word = 16'h1201;
        6'd3:    seq_word = 16'h1300;
        6'd4:    seq_word = 16'hA503;
        6'd5:    seq_word = 16'hA620;
        6'd6:    seq_word = 16'hAB03;
        6'd7:    seq_word = 16'hAC03;
        6'd8:    seq_word = 16'hAD08;
        6'd9:    seq_word = 16'hAE08;
        6'd10:   seq_word = 16'h6402;
        6'd11:   seq_word = 16'h1100;
        6'd12:   seq_word = 16'h1260;
        6'd13:   seq_word = 16'h1300;
        6'd14:   seq_word = 16'h260F;
        6'd15:   seq_word = 16'h2080;
        6'd16:   seq_word = 16'h11FF;
        6'd17:   seq_word = 16'h1200;
        6'd18:   seq_word = 16'h1300;
        6'd19:   seq_word = 16'hD508;
        6'd20:   seq_word = 16'hD500;
        6'd21:   seq_word = 16'h2A00;
        6'd22:   seq_word = 16'hCF50;
        6'd23:   seq_word = 16'h1100;
        6'd24:   seq_word = 16'h121E;
        6'd25:   seq_word = 16'h1300;
        6'd26:   seq_word = 16'h2D02;
        6'd27:   seq_word = 16'h1100;
        6'd28:   seq_word = 16'h1201;
        6'd29:   seq_word = 16'h1300;
        6'd30:   seq_word = 16'h8C02;
        6'd31:   seq_word = 16'hB701;
        6'd32:   seq_word = 16'hB700;
        6'd33:   seq_word = 16'h1100;
        6'd34:   seq_word = 16'h1200;
        6'd35:   seq_word = 16'h1301;
        6'd36:   seq_word = 16'h6A02;
        default: seq_word = 16'h0000;
      endcase
    end
  endfunction

  // Index of the last write in the table above.
  localparam [5:0] LAST_STEP = 6'd36;
  localparam [5:0] CAL_STEP  = 6'd20;

  // Current and following table words; a function result cannot be part-selected directly.
  wire [15:0] cur_word;
  wire [15:0] nxt_word;
  assign cur_word = seq_word(step);
  assign nxt_word = seq_word(step + 6'd1);

  // The clock-ready level comes from outside, so it is synchronised first.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
    end else begin
      ready_meta <= clocks_ready;
      ready_sync <= ready_meta;
    end
  end

  // Host register writes; start is held until the sequencer takes it.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start_req <= 1'b0;
      divider   <= `DIVIDER_RESET;
    end else begin
      if (wr && addr == `REG_CONTROL && wdata[`CTRL_START_BIT]) begin
        start_req <= 1'b1;
      end else if (state == S_POWERUP) begin
        start_req <= 1'b0;
      end
      if (wr && addr == `REG_DIVIDER && wdata != 8'h00) begin
        divider <= wdata;
      end
    end
  end

  // Read data stands in the cycle after the strobe only.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `REG_CONTROL: rdata <= {7'h00, start_req};
        `REG_STATUS:  rdata <= {5'h00, state == S_CALWAIT, done, state != S_IDLE && state != S_DONE};
        `REG_STEP:    rdata <= {2'h0, step};
        default:      rdata <= divider;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Next-state decision; serial work waits for running clocks.
  always @* begin
    next_state = state;
    case (state)
      S_IDLE:    if (start_req && ready_sync) next_state = S_POWERUP;
      S_POWERUP: if (timer == 32'd0) next_state = S_PULSE;
      S_PULSE:   if (timer == 32'd0) next_state = S_RELEASE;
      S_RELEASE: if (timer == 32'd0) next_state = S_SHIFT;
      S_SHIFT:   if (bit_cnt == 5'd0 && half_cnt == 8'd0 && sclk) next_state = S_GAP;
      S_GAP: begin
        if (timer == 32'd0) begin
          if (step == LAST_STEP) begin
            next_state = S_DONE;
          end else if (step + 6'd1 == CAL_STEP) begin
            next_state = S_CALWAIT;
          end else begin
            next_state = S_SHIFT;
          end
        end
      end
      S_CALWAIT: if (timer == 32'd0) next_state = S_SHIFT;
      S_DONE:    next_state = S_DONE;
      default:   next_state = S_IDLE;
    endcase
  end

  // Sequencer datapath: timers, serial shifting and step advance.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state                <= S_IDLE;
      timer                <= 32'd0;
      step                 <= 6'd0;
      bit_cnt              <= 5'd0;
      shift                <= 16'h0000;
      half_cnt             <= 8'h00;
      hw_reset             <= 1'b0;
      serial_port_select_b <= 1'b1;
      sclk                 <= 1'b0;
      sdata                <= 1'b0;
      done                 <= 1'b0;
    end else begin
      state <= next_state;
      if (timer != 32'd0) begin
        timer <= timer - 32'd1;
      end
      case (state)
        S_IDLE: begin
          timer <= POWERUP_CYCLES - 1;
        end
        S_POWERUP: begin
          if (timer == 32'd0) begin
            hw_reset <= 1'b1;
            timer    <= `RESET_CYCLES - 1;
          end
        end
        S_PULSE: begin
          if (timer == 32'd0) begin
            hw_reset <= 1'b0;
            timer    <= RELEASE_CYCLES - 1;
          end
        end
        S_RELEASE, S_CALWAIT: begin
          if (timer == 32'd0) begin
            // Frame opens with select low; first bit is put out before any clock edge.
            serial_port_select_b <= 1'b0;
            shift    <= {cur_word[14:0], 1'b0};
            sdata    <= cur_word[15];
            bit_cnt  <= 5'd15;
            half_cnt <= divider;
            sclk     <= 1'b0;
          end
        end
        S_SHIFT: begin
          // Device samples on the rising edge; data changes on the falling edge.
          if (half_cnt != 8'h00) begin
            half_cnt <= half_cnt - 8'h01;
          end else begin
            half_cnt <= divider;
            sclk     <= ~sclk;
            if (sclk) begin
              if (bit_cnt != 5'd0) begin
                bit_cnt <= bit_cnt - 5'd1;
                sdata   <= shift[15];
                shift   <= {shift[14:0], 1'b0};
              end else begin
                serial_port_select_b <= 1'b1;
                timer                <= {24'h000000, divider};
              end
            end
          end
        end
        S_GAP: begin
          // A write is complete before the next one is started.
          if (timer == 32'd0) begin
            step <= step + 6'd1;
            if (step == LAST_STEP) begin
              done <= 1'b1;
            end else if (step + 6'd1 == CAL_STEP) begin
              timer <= CAL_CYCLES - 1;
            end else begin
              serial_port_select_b <= 1'b0;
              shift    <= {nxt_word[14:0], 1'b0};
              sdata    <= nxt_word[15];
              bit_cnt  <= 5'd15;
              half_cnt <= divider;
            end
          end
        end
        default: begin
          timer <= 32'd0;
        end
      endcase
    end
  end

endmodule // adc_startup_config_sequencer

// ==== src/startup_seq_consts.vh ====
// Constants for the converter start-up sequencer.
`ifndef STARTUP_SEQ_CONSTS_VH
`define STARTUP_SEQ_CONSTS_VH
// Host command and status register offsets.
`define REG_CONTROL        2'h0
`define REG_STATUS         2'h1
`define REG_STEP           2'h2
`define REG_DIVIDER        2'h3
// Control register field positions.
`define CTRL_START_BIT     0
`define CTRL_RESET_BIT     1
// Status register field positions.
`define STAT_BUSY_BIT      0
`define STAT_DONE_BIT      1
`define STAT_CAL_BIT       2
// Reset value of the serial clock half-period count.
`define DIVIDER_RESET      8'h04
// Timing figures in their own units and the clock period in picoseconds.
`define CLK_PERIOD_PS      5000
`define POWERUP_WAIT_US    1000
`define RESET_PULSE_NS     10
`define RESET_RELEASE_US   100
`define CAL_WAIT_US        2000
// Cycle counts, rounded up because every figure is a least time.
`define POWERUP_CYCLES     ((`POWERUP_WAIT_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_CYCLES       ((`RESET_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RELEASE_CYCLES     ((`RESET_RELEASE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CAL_CYCLES         ((`CAL_WAIT_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Write count and wait slot index, unused; the sequencer holds 37 writes and waits before step 20.
`define SEQ_LENGTH         6'd41
`define CAL_WAIT_STEP      6'd27
`endif
